// ---- src/iev_pkg.sv ----
// shared constants for the interrupt enable and vectoring block
// assumes a single core clock domain and an AHB-Lite register port
//
// Operation
// - enable bit 4 masks the serial port interrupt when clear.
// - enable bit 2 masks external interrupt 1 when clear.
// - enable bit 1 masks the timer 0 overflow interrupt when clear.
// - enable bit 0 masks external interrupt 0 when clear.
// - enable register resets to zero; every bit writable alone.
// - timer 0 overflow requests vector 000Bh, polling entry 2.
// - timer 1 overflow requests vector 001Bh, polling entry 4.
// - serial receive or transmit done requests vector 0023h, rank 6.
// - timer 2 overflow or external flag requests vector 002Bh, rank 7.
// - counter array overflow or module flags request vector 0033h, rank 5.
// - keypad flag requests vector 003Bh, polling entry 8.
// - external 0 to 0003h, external 1 to 0013h, serial link to 004Bh.
// - reset starts at 0000h; fixed polling order breaks ties.
// - enable bit 7 is a global enable over all sources.
// - enable bit 5 masks the timer 2 interrupt when clear.
// - enable bit 6 masks the counter array interrupt when clear.
// - four priority levels per source; polling order only breaks ties.

package iev_pkg;

   // ----------------------------------------------------------------
   // source numbering, in polling order
   // ----------------------------------------------------------------
   localparam int NUM_SRC   = 9;
   localparam int SRC_EXT0  = 0;
   localparam int SRC_TMR0  = 1;
   localparam int SRC_EXT1  = 2;
   localparam int SRC_TMR1  = 3;
   localparam int SRC_PCA   = 4;
   localparam int SRC_UART  = 5;
   localparam int SRC_TMR2  = 6;
   localparam int SRC_KBD   = 7;
   localparam int SRC_SPI   = 8;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_IEN_LO   = 8'h00;
   localparam logic [7:0] OFS_IEN_SET  = 8'h04;
   localparam logic [7:0] OFS_IEN_CLR  = 8'h08;
   localparam logic [7:0] OFS_IEN_HI   = 8'h0C;
   localparam logic [7:0] OFS_PRIO_LO  = 8'h10;
   localparam logic [7:0] OFS_PRIO_HI  = 8'h14;
   localparam logic [7:0] OFS_EXT_MODE = 8'h18;
   localparam logic [7:0] OFS_PENDING  = 8'h1C;
   localparam logic [7:0] OFS_CORE     = 8'h20;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int BIT_EXT0 = 0;
   localparam int BIT_TMR0 = 1;
   localparam int BIT_EXT1 = 2;
   localparam int BIT_TMR1 = 3;
   localparam int BIT_UART = 4;
   localparam int BIT_TMR2 = 5;
   localparam int BIT_PCA  = 6;
   localparam int BIT_GLB  = 7;
   localparam int BIT_EKBD = 0;
   localparam int BIT_ESPI = 1;
   localparam int CORE_LEVEL_POS = 16;
   localparam int CORE_REQ_POS   = 18;
   localparam int CORE_ISR_POS   = 20;
   localparam logic [7:0] RST_IEN_LO   = 8'h00;
   localparam logic [1:0] RST_IEN_HI   = 2'h0;
   localparam logic [8:0] RST_PRIO     = 9'h000;
   localparam logic [1:0] RST_EXT_MODE = 2'h0;

   // ----------------------------------------------------------------
   // vectors
   // ----------------------------------------------------------------
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_EXT0  = 16'h0003;
   localparam logic [15:0] VEC_TMR0  = 16'h000B;
   localparam logic [15:0] VEC_EXT1  = 16'h0013;
   localparam logic [15:0] VEC_TMR1  = 16'h001B;
   localparam logic [15:0] VEC_UART  = 16'h0023;
   localparam logic [15:0] VEC_TMR2  = 16'h002B;
   localparam logic [15:0] VEC_PCA   = 16'h0033;
   localparam logic [15:0] VEC_KBD   = 16'h003B;
   localparam logic [15:0] VEC_SPI   = 16'h004B;

   // vector lookup by source index
   function automatic logic [15:0] iev_vector(input logic [3:0] idx);
      case (idx)
         4'h0:    iev_vector = VEC_EXT0;
         4'h1:    iev_vector = VEC_TMR0;
         4'h2:    iev_vector = VEC_EXT1;
         4'h3:    iev_vector = VEC_TMR1;
         4'h4:    iev_vector = VEC_PCA;
         4'h5:    iev_vector = VEC_UART;
         4'h6:    iev_vector = VEC_TMR2;
         4'h7:    iev_vector = VEC_KBD;
         4'h8:    iev_vector = VEC_SPI;
         default: iev_vector = VEC_RESET;
      endcase
   endfunction : iev_vector

endpackage : iev_pkg

// ---- src/iev_sync.sv ----
// two-stage synchroniser for asynchronous pin levels
// assumes the destination clock is the only clock
`timescale 1ns/1ps

module iev_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   input  wire logic [WIDTH-1:0] i_rst_val,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_reg;

   // ----------------------------------------------------------------
   // two flops; the first is read by the second only
   // ----------------------------------------------------------------
   // pins are idle high, so reset to ones rather than a port value
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= '1;
         o_sync   <= '1;
      end else begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end

endmodule : iev_sync

// ---- src/iev_arbiter.sv ----
// priority pick among enabled requests
// assumes requests are indexed in polling order, lowest index first
`timescale 1ns/1ps

module iev_arbiter #(
   parameter int NSRC = 9
) (
   input  wire logic [NSRC-1:0] i_req,
   input  wire logic [NSRC-1:0] i_prio_lo,
   input  wire logic [NSRC-1:0] i_prio_hi,
   output logic                 o_valid,
   output logic [3:0]           o_idx,
   output logic [1:0]           o_level
);

   // ----------------------------------------------------------------
   // highest level first, then lowest polling index
   // ----------------------------------------------------------------
   // level scan outside, index scan inside: ties broken by order only
   always_comb begin
      o_valid = 1'b0;
      o_idx   = 4'h0;
      o_level = 2'h0;
      for (int lvl = 3; lvl >= 0; lvl--) begin
         for (int i = NSRC - 1; i >= 0; i--) begin
            if (!o_valid && i_req[i] && ({i_prio_hi[i], i_prio_lo[i]} == 2'(lvl))) begin
               o_idx   = 4'(i);
               o_level = 2'(lvl);
            end
         end
         if (!o_valid && (i_req & ~(i_prio_hi ^ {NSRC{lvl[1]}}) & ~(i_prio_lo ^ {NSRC{lvl[0]}})) != '0) begin
            o_valid = 1'b1;
         end
      end
   end

endmodule : iev_arbiter

// ---- src/iev_top.sv ----
// interrupt enable and vectoring block with AHB-Lite register port
// assumes peripheral flags on the core clock; external pins asynchronous
`timescale 1ns/1ps

module iev_top (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // external pins, active low
   input  wire logic        i_ext_irq_pin0,
   input  wire logic        i_ext_irq_pin1,
   // peripheral request flags
   input  wire logic        i_timer0_overflow,
   input  wire logic        i_timer1_overflow,
   input  wire logic        i_timer2_overflow,
   input  wire logic        i_timer2_ext_flag,
   input  wire logic        i_uart_recv_done,
   input  wire logic        i_uart_xmit_done,
   input  wire logic        i_pca_overflow_flag,
   input  wire logic [4:0]  i_pca_module_flags,
   input  wire logic        i_keypad_irq_flag,
   input  wire logic        i_serial_periph_irq_flag,
   // processor core
   input  wire logic        i_irq_ack,
   input  wire logic        i_irq_return,
   output logic             o_irq_req,
   output logic      [15:0] o_irq_vector,
   output logic      [1:0]  o_irq_level,
   output logic      [8:0]  o_ack_source
);

   localparam int NS = iev_pkg::NUM_SRC;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [7:0]    interrupt_enable_lo_reg;
   logic [1:0]    interrupt_enable_hi_reg;
   logic [NS-1:0] prio_lo_reg;
   logic [NS-1:0] prio_hi_reg;
   logic [1:0]    ext_mode_reg;
   logic [1:0]    ext0_1_pending_reg;
   logic [1:0]    pin_sync;
   logic [1:0]    pin_last_reg;
   logic [1:0]    pin_fall;
   logic [3:0]    in_service_reg;
   logic [3:0]    sel_idx_reg;
   logic          wr_pend_reg;
   logic          rd_pend_reg;
   logic [7:0]    addr_reg;
   logic [NS-1:0] req_raw;
   logic [NS-1:0] src_enable;
   logic [NS-1:0] req_masked;
   logic          arb_valid;
   logic [3:0]    arb_idx;
   logic [1:0]    arb_level;
   logic          level_allowed;
   logic          take_ack;
   logic [NS-1:0] ack_onehot;
   logic          addr_phase;
   logic          global_enable;

   // ----------------------------------------------------------------
   // external pin capture
   // ----------------------------------------------------------------
   iev_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_async   ({i_ext_irq_pin1, i_ext_irq_pin0}),
      .i_rst_val (2'h3),
      .o_sync    (pin_sync)
   );

   // previous synced level for falling-edge detection
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_last_reg <= 2'h3;
      end else begin
         pin_last_reg <= pin_sync;
      end
   end

   assign pin_fall = pin_last_reg & ~pin_sync;

   // core ack of an external source clears its edge flag
   assign take_ack = i_irq_ack & o_irq_req;

   // one-hot decode of the acknowledged source
   always_comb begin
      ack_onehot = '0;
      if (take_ack) begin
         ack_onehot[sel_idx_reg] = 1'b1;
      end
   end

   // pending flags: level mode follows the pin, edge mode latches
   // a new falling edge wins over the ack that would clear it
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ext0_1_pending_reg <= 2'h0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (!ext_mode_reg[k]) begin
               ext0_1_pending_reg[k] <= ~pin_sync[k];
            end else if (pin_fall[k]) begin
               ext0_1_pending_reg[k] <= 1'b1;
            end else if (ack_onehot[2 * k]) begin
               ext0_1_pending_reg[k] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // request gathering, polling order indices
   // ----------------------------------------------------------------
   // ext pending flags feed the first and third slots
   assign req_raw[iev_pkg::SRC_EXT0] = ext0_1_pending_reg[0];
   assign req_raw[iev_pkg::SRC_TMR0] = i_timer0_overflow;
   assign req_raw[iev_pkg::SRC_EXT1] = ext0_1_pending_reg[1];
   assign req_raw[iev_pkg::SRC_TMR1] = i_timer1_overflow;
   assign req_raw[iev_pkg::SRC_PCA]  = i_pca_overflow_flag | (|i_pca_module_flags);
   assign req_raw[iev_pkg::SRC_UART] = i_uart_recv_done | i_uart_xmit_done;
   assign req_raw[iev_pkg::SRC_TMR2] = i_timer2_overflow | i_timer2_ext_flag;
   assign req_raw[iev_pkg::SRC_KBD]  = i_keypad_irq_flag;
   assign req_raw[iev_pkg::SRC_SPI]  = i_serial_periph_irq_flag;

   // per-source enables from the two enable registers
   assign src_enable[iev_pkg::SRC_EXT0] = interrupt_enable_lo_reg[iev_pkg::BIT_EXT0];
   assign src_enable[iev_pkg::SRC_TMR0] = interrupt_enable_lo_reg[iev_pkg::BIT_TMR0];
   assign src_enable[iev_pkg::SRC_EXT1] = interrupt_enable_lo_reg[iev_pkg::BIT_EXT1];
   assign src_enable[iev_pkg::SRC_TMR1] = interrupt_enable_lo_reg[iev_pkg::BIT_TMR1];
   assign src_enable[iev_pkg::SRC_PCA]  = interrupt_enable_lo_reg[iev_pkg::BIT_PCA];
   assign src_enable[iev_pkg::SRC_UART] = interrupt_enable_lo_reg[iev_pkg::BIT_UART];
   assign src_enable[iev_pkg::SRC_TMR2] = interrupt_enable_lo_reg[iev_pkg::BIT_TMR2];
   assign src_enable[iev_pkg::SRC_KBD]  = interrupt_enable_hi_reg[iev_pkg::BIT_EKBD];
   assign src_enable[iev_pkg::SRC_SPI]  = interrupt_enable_hi_reg[iev_pkg::BIT_ESPI];

   // global enable overrides every individual bit
   assign global_enable = interrupt_enable_lo_reg[iev_pkg::BIT_GLB];
   assign req_masked    = req_raw & src_enable & {NS{global_enable}};

   // ----------------------------------------------------------------
   // arbitration and nesting
   // ----------------------------------------------------------------
   iev_arbiter #(
      .NSRC (NS)
   ) u_arbiter (
      .i_req     (req_masked),
      .i_prio_lo (prio_lo_reg),
      .i_prio_hi (prio_hi_reg),
      .o_valid   (arb_valid),
      .o_idx     (arb_idx),
      .o_level   (arb_level)
   );

   // a request may only preempt a strictly lower level in service
   always_comb begin
      level_allowed = 1'b1;
      for (int l = 0; l < 4; l++) begin
         if (in_service_reg[l] && (arb_level <= 2'(l))) begin
            level_allowed = 1'b0;
         end
      end
   end

   // in-service levels: ack marks, return clears the highest one
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         in_service_reg <= 4'h0;
      end else if (take_ack) begin
         in_service_reg[o_irq_level] <= 1'b1;
      end else if (i_irq_return) begin
         if (in_service_reg[3]) begin
            in_service_reg[3] <= 1'b0;
         end else if (in_service_reg[2]) begin
            in_service_reg[2] <= 1'b0;
         end else if (in_service_reg[1]) begin
            in_service_reg[1] <= 1'b0;
         end else begin
            in_service_reg[0] <= 1'b0;
         end
      end
   end

   // request and vector to the core; vector holds while idle
   // ack cycle drops the request so it is not taken twice
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_req    <= 1'b0;
         o_irq_vector <= iev_pkg::VEC_RESET;
         o_irq_level  <= 2'h0;
         sel_idx_reg  <= 4'h0;
      end else begin
         o_irq_req <= arb_valid & level_allowed & ~take_ack;
         if (arb_valid && level_allowed && !take_ack) begin
            o_irq_vector <= iev_pkg::iev_vector(arb_idx);
            o_irq_level  <= arb_level;
            sel_idx_reg  <= arb_idx;
         end
      end
   end

   // one-cycle notice to peripherals whose flags self-clear on ack
   // flags that do not self-clear are left to service software
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ack_source <= '0;
      end else begin
         o_ack_source <= ack_onehot;
      end
   end

   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   assign addr_phase = i_hsel & i_hready & i_htrans[1];

   // address phase capture; reads take one wait state so a read
   // right behind a write sees the written value
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
         o_hreadyout <= 1'b1;
      end else begin
         if (rd_pend_reg) begin
            rd_pend_reg <= 1'b0;
            o_hreadyout <= 1'b1;
         end else if (addr_phase) begin
            wr_pend_reg <= i_hwrite;
            rd_pend_reg <= ~i_hwrite;
            o_hreadyout <= i_hwrite;
            addr_reg    <= i_haddr[7:0];
         end else begin
            wr_pend_reg <= 1'b0;
         end
      end
   end

   // response is always okay
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hresp <= 1'b0;
      end else begin
         o_hresp <= 1'b0;
      end
   end

   // enable register: whole write, or single-bit set/clear strobes
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         interrupt_enable_lo_reg <= iev_pkg::RST_IEN_LO;
      end else if (wr_pend_reg) begin
         if (addr_reg == iev_pkg::OFS_IEN_LO) begin
            interrupt_enable_lo_reg <= i_hwdata[7:0];
         end else if (addr_reg == iev_pkg::OFS_IEN_SET) begin
            interrupt_enable_lo_reg <= interrupt_enable_lo_reg | i_hwdata[7:0];
         end else if (addr_reg == iev_pkg::OFS_IEN_CLR) begin
            interrupt_enable_lo_reg <= interrupt_enable_lo_reg & ~i_hwdata[7:0];
         end
      end
   end

   // remaining control registers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         interrupt_enable_hi_reg <= iev_pkg::RST_IEN_HI;
         prio_lo_reg             <= iev_pkg::RST_PRIO;
         prio_hi_reg             <= iev_pkg::RST_PRIO;
         ext_mode_reg            <= iev_pkg::RST_EXT_MODE;
      end else if (wr_pend_reg) begin
         if (addr_reg == iev_pkg::OFS_IEN_HI) begin
            interrupt_enable_hi_reg <= i_hwdata[1:0];
         end else if (addr_reg == iev_pkg::OFS_PRIO_LO) begin
            prio_lo_reg <= i_hwdata[NS-1:0];
         end else if (addr_reg == iev_pkg::OFS_PRIO_HI) begin
            prio_hi_reg <= i_hwdata[NS-1:0];
         end else if (addr_reg == iev_pkg::OFS_EXT_MODE) begin
            ext_mode_reg <= i_hwdata[1:0];
         end
      end
   end

   // read data loaded during the wait cycle; unmapped reads zero
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hrdata <= 32'h0000_0000;
      end else if (rd_pend_reg) begin
         if (addr_reg == iev_pkg::OFS_IEN_LO) begin
            o_hrdata <= {24'h00_0000, interrupt_enable_lo_reg};
         end else if (addr_reg == iev_pkg::OFS_IEN_HI) begin
            o_hrdata <= {30'h0000_0000, interrupt_enable_hi_reg};
         end else if (addr_reg == iev_pkg::OFS_PRIO_LO) begin
            o_hrdata <= {23'h00_0000, prio_lo_reg};
         end else if (addr_reg == iev_pkg::OFS_PRIO_HI) begin
            o_hrdata <= {23'h00_0000, prio_hi_reg};
         end else if (addr_reg == iev_pkg::OFS_EXT_MODE) begin
            o_hrdata <= {30'h0000_0000, ext_mode_reg};
         end else if (addr_reg == iev_pkg::OFS_PENDING) begin
            o_hrdata <= {23'h00_0000, req_raw};
         end else if (addr_reg == iev_pkg::OFS_CORE) begin
            o_hrdata <= {8'h00, in_service_reg, 1'b0, o_irq_req, o_irq_level, o_irq_vector};
         end else begin
            o_hrdata <= 32'h0000_0000;
         end
      end
   end

endmodule : iev_top

// ---- verification/iev_core_model.sv ----
// core model: takes a presented vector after a set delay, returns later
// assumes one clock and the reset shared with the vectoring block
`timescale 1ns/1ps

module iev_core_model (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic        i_irq_req,
   input  wire logic [15:0] i_irq_vector,
   input  wire logic [3:0]  i_delay,
   output logic             o_irq_ack,
   output logic             o_irq_return,
   output logic      [15:0] o_taken_vec
);
   // ----------------------------------------------
   // ack and service timing
   // ----------------------------------------------
   logic [3:0] cnt_reg;
   logic [2:0] svc_reg;

   // service lasts seven cycles, long enough for a released pin to resync
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_ack    <= 1'b0;
         o_irq_return <= 1'b0;
         o_taken_vec  <= 16'h0000;
         cnt_reg      <= 4'h0;
         svc_reg      <= 3'h0;
      end
      else begin
         o_irq_ack    <= 1'b0;
         o_irq_return <= (svc_reg == 3'h1);
         if (svc_reg != 3'h0) begin
            svc_reg <= svc_reg - 3'h1;
         end
         else if (i_irq_req && !o_irq_ack) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg >= i_delay) begin
               o_irq_ack   <= 1'b1;
               o_taken_vec <= i_irq_vector;
               svc_reg     <= 3'h7;
               cnt_reg     <= 4'h0;
            end
         end
      end
   end
endmodule : iev_core_model

// ---- verification/iev_top_assertions.sv ----
// port checker for the vectoring block
// assumes one clock domain; bound to iev_top from the bench
`timescale 1ns/1ps

module iev_top_assertions (
   input wire logic        i_ref_clk,
   input wire logic        i_rst,
   input wire logic        i_timer0_overflow,
   input wire logic        i_timer1_overflow,
   input wire logic        i_timer2_overflow,
   input wire logic        i_timer2_ext_flag,
   input wire logic        i_uart_recv_done,
   input wire logic        i_uart_xmit_done,
   input wire logic        i_pca_overflow_flag,
   input wire logic [4:0]  i_pca_module_flags,
   input wire logic        i_irq_ack,
   input wire logic        o_irq_req,
   input wire logic [15:0] o_irq_vector,
   input wire logic [8:0]  o_ack_source
);
   // ----------------------------------------------
   // request, vector and ack relations
   // ----------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   // a new request names its vector in the same cycle
   sequence sr(logic [15:0] v);
      $rose(o_irq_req) && o_irq_vector == v;
   endsequence

   chk_ack_drops_req: assert property (i_irq_ack && o_irq_req |=> !o_irq_req)
      else $error("request held after ack");
   chk_ack_source_pulse: assert property (
      i_irq_ack && o_irq_req |=> $onehot(o_ack_source) ##1 o_ack_source == 9'h000) else $error("bad ack pulse");
   chk_reset_vector: assert property (
      disable iff (1'b0) $fell(i_rst) |-> o_irq_vector == iev_pkg::VEC_RESET && !o_irq_req) else $error("reset vec");
   chk_tmr0_flag: assert property (sr(iev_pkg::VEC_TMR0) |-> $past(i_timer0_overflow))
      else $error("timer0 vector without flag");
   chk_tmr1_flag: assert property (sr(iev_pkg::VEC_TMR1) |-> $past(i_timer1_overflow))
      else $error("timer1 vector without flag");
   chk_uart_flags: assert property (
      sr(iev_pkg::VEC_UART) |-> $past(i_uart_recv_done || i_uart_xmit_done)) else $error("uart vector without flag");
   chk_tmr2_flags: assert property (
      sr(iev_pkg::VEC_TMR2) |-> $past(i_timer2_overflow || i_timer2_ext_flag)) else $error("timer2 without flag");
   chk_pca_flags: assert property (
      sr(iev_pkg::VEC_PCA) |-> $past(i_pca_overflow_flag || |i_pca_module_flags)) else $error("pca without flag");

   cover property (i_irq_ack && o_irq_req);
   cover property (sr(iev_pkg::VEC_SPI));
   cover property (sr(iev_pkg::VEC_EXT1));
endmodule : iev_top_assertions

// ---- verification/tb_top.sv ----
// self-checking bench for the vectoring block
// assumes the core model and the checker are compiled before this file
`timescale 1ns/1ps

module tb_top;
   logic        clk, rst, hsel, hwrite, hready, ack, ret, alt, req;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [8:0]  src;
   logic [3:0]  dly;
   logic [15:0] tvec, vec;
   int          errors, samples_checked, cyc;
   // vectors and enable bit positions by polling index; ORD is the expected service order
   localparam logic [15:0] VEC [9] = '{iev_pkg::VEC_EXT0, iev_pkg::VEC_TMR0, iev_pkg::VEC_EXT1,
      iev_pkg::VEC_TMR1, iev_pkg::VEC_PCA, iev_pkg::VEC_UART, iev_pkg::VEC_TMR2, iev_pkg::VEC_KBD, iev_pkg::VEC_SPI};
   localparam int EBIT [9] = '{0, 1, 2, 3, 6, 4, 5, 8, 9};
   localparam int ORD [9] = '{6, 0, 1, 2, 3, 4, 5, 7, 8};

   iev_top i_dut (.i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(), .i_ext_irq_pin0(!src[0]), .i_ext_irq_pin1(!src[2]),
      .i_timer0_overflow(src[1]), .i_timer1_overflow(src[3]), .i_timer2_overflow(src[6] && !alt),
      .i_timer2_ext_flag(src[6] && alt), .i_uart_recv_done(src[5] && !alt), .i_uart_xmit_done(src[5] && alt),
      .i_pca_overflow_flag(src[4] && !alt), .i_pca_module_flags({4'h0, src[4] && alt}),
      .i_keypad_irq_flag(src[7]), .i_serial_periph_irq_flag(src[8]), .i_irq_ack(ack), .i_irq_return(ret),
      .o_irq_req(req), .o_irq_vector(vec), .o_irq_level(), .o_ack_source());
   iev_core_model i_core (.i_ref_clk(clk), .i_rst(rst), .i_irq_req(req), .i_irq_vector(vec),
      .i_delay(dly), .o_irq_ack(ack), .o_irq_return(ret), .o_taken_vec(tvec));

   // ----------------------------------------------
   // clock, hang limit and shared tasks
   // ----------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // whole run needs about 450 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         results();
      end
   end
   task automatic results();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end
      else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // single word transfer; hsel stays up, idle htrans ends the access
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h00000000, r);
      cmp(r, e);
   endtask : rd
   task automatic en(input logic [9:0] e);
      wr(8'h00, {24'h000000, e[7:0]});
      wr(8'h0C, {30'h00000000, e[9:8]});
   endtask : en
   task automatic grab(input logic [15:0] e);
      do @(posedge clk); while (ack !== 1'b1);
      cmp({16'h0000, tvec}, {16'h0000, e});
   endtask : grab

   // ----------------------------------------------
   // main sequence
   // ----------------------------------------------
   initial begin
      {rst, hsel, hwrite, alt, haddr, hwdata, htrans, hsize, src, dly} = {1'b1, 85'h0};
      hsize = 3'h2;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h00, 32'h00000000);
      wr(8'h00, 32'h000000FF);
      rd(8'h00, 32'h000000FF);
      wr(8'h08, 32'h00000080);
      rd(8'h00, 32'h0000007F);
      rd(8'h40, 32'h00000000);
      // each source alone: masked by its own bit, then taken with its vector
      for (int i = 0; i < 9; i++) begin
         en(10'h3FF ^ (10'h001 << EBIT[i]));
         src <= 9'h001 << i;
         repeat (8) @(posedge clk);
         cmp({31'h0, req}, 32'h0);
         en(10'h3FF);
         grab(VEC[i]);
         src <= 9'h000;
         repeat (10) @(posedge clk);
      end
      // pins on falling edge, all pending with global enable off, then timer 2 raised to level 2
      wr(8'h18, 32'h00000003);
      en(10'h37F);
      alt <= 1'b1;
      dly <= 4'h5;
      src <= 9'h1FF;
      repeat (8) @(posedge clk);
      cmp({31'h0, req}, 32'h0);
      rd(8'h1C, 32'h000001FF);
      wr(8'h14, 32'h00000040);
      wr(8'h04, 32'h00000080);
      for (int k = 0; k < 9; k++) begin
         grab(VEC[ORD[k]]);
         src[ORD[k]] <= 1'b0;
      end
      results();
   end
endmodule : tb_top

bind iev_top iev_top_assertions i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_timer0_overflow(i_timer0_overflow),
   .i_timer1_overflow(i_timer1_overflow), .i_timer2_overflow(i_timer2_overflow), .i_timer2_ext_flag(i_timer2_ext_flag),
   .i_uart_recv_done(i_uart_recv_done), .i_uart_xmit_done(i_uart_xmit_done), .i_irq_ack(i_irq_ack),
   .i_pca_overflow_flag(i_pca_overflow_flag), .i_pca_module_flags(i_pca_module_flags), .o_irq_req(o_irq_req),
   .o_irq_vector(o_irq_vector), .o_ack_source(o_ack_source));
